// >>> rtl/rpi_defs.vh
// Constants for the periodic pulse and interrupt block of the real-time clock.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef RPI_DEFS_VH
`define RPI_DEFS_VH

// Clock rate and base timing.
`define RPI_CLK_MHZ 250
`define RPI_TICK_US 15625
// One 1/64 s tick is 15625 us at 250 MHz, 3906250 cycles; the pulse holds for half of it.
// Both are written at the 22-bit width of the counters that load them.
`define RPI_TICK_CYCLES 22'h3b9aca
`define RPI_PULSE_CYCLES 22'h1dcd65
`define RPI_SUBS_LAST 6'h3f
`define RPI_SEC_LAST 6'h3b
`define RPI_MIN_LAST 6'h3b
`define RPI_BUSY_CYCLES 22'h000008

// Period selector codes.
`define RPI_SEL_64HZ 2'h0
`define RPI_SEL_SEC 2'h1
`define RPI_SEL_MIN 2'h2
`define RPI_SEL_HOUR 2'h3

// Register byte offsets.
`define RPI_OFS_CTRL 8'h00
`define RPI_OFS_FLAG 8'h04
`define RPI_OFS_TIME 8'h08
`define RPI_OFS_ISTAT 8'h0c
`define RPI_OFS_IEN 8'h10
`define RPI_OFS_ICLR 8'h14

// Control register fields.
`define RPI_CTRL_HOLD 0
`define RPI_CTRL_SEL_LO 1
`define RPI_CTRL_SEL_HI 2
`define RPI_CTRL_MODE 3
`define RPI_CTRL_MASK 4
`define RPI_CTRL_RESET 5'h00

// Flag register fields.
`define RPI_FLAG_EVT 0
`define RPI_FLAG_BUSY 1

// Bus responses.
`define RPI_RESP_OKAY 2'h0
`define RPI_RESP_SLVERR 2'h2

`endif

// >>> rtl/rpi_period_gen.v
// Timebase of the periodic output: 1/64 s ticks, seconds, minutes and hours.
// Assumes one free-running system clock; period events are one-cycle pulses.
`timescale 1ns/1ns
`include "rpi_defs.vh"

module rpi_period_gen #(
  parameter [21:0] TICK_CYCLES = `RPI_TICK_CYCLES
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Period events.
  output wire tick_64,
  output wire tick_sec,
  output wire tick_min,
  output wire tick_hour,
  // Counter state.
  output wire busy_win,
  output wire [5:0] sec_cnt,
  output wire [5:0] min_cnt
);

reg [21:0] cyc_q;
reg [5:0] sub_q;
reg [5:0] sec_q;
reg [5:0] min_q;
wire cyc_end;

// A 1/64 s tick divides the 250 MHz clock exactly, so no fractional logic is needed.
assign cyc_end = (cyc_q == TICK_CYCLES - 22'h000001);
assign tick_64 = cyc_end;
assign tick_sec = cyc_end && (sub_q == `RPI_SUBS_LAST);
assign tick_min = tick_sec && (sec_q == `RPI_SEC_LAST);
assign tick_hour = tick_min && (min_q == `RPI_MIN_LAST);
// Busy covers the last few cycles before the seconds carry ripples upward.
assign busy_win = (sub_q == `RPI_SUBS_LAST) && (cyc_q >= TICK_CYCLES - `RPI_BUSY_CYCLES); // R7
assign sec_cnt = sec_q;
assign min_cnt = min_q;

////////////////////////////////////////////////////////////////////////////////
// Cascaded counters; each stage advances only on the carry of the one below.
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    cyc_q <= 22'h000000;
    sub_q <= 6'h00;
    sec_q <= 6'h00;
    min_q <= 6'h00;
  end
  else
  begin
    cyc_q <= cyc_end ? 22'h000000 : cyc_q + 22'h000001;
    if (cyc_end)
      sub_q <= sub_q + 6'h01;
    if (tick_sec)
      sec_q <= (sec_q == `RPI_SEC_LAST) ? 6'h00 : sec_q + 6'h01;
    if (tick_min)
      min_q <= (min_q == `RPI_MIN_LAST) ? 6'h00 : min_q + 6'h01;
  end
end

endmodule // rpi_period_gen

// >>> rtl/rpi_top.v
// Periodic pulse and interrupt output of the real-time clock, with AXI4-Lite registers.
// Assumes an external pull-up on the open-drain periodic pin and one 250 MHz clock.
//
// Summary of operation
// R1 - Unmasked: mode bit 0 pulse, 1 interrupt; event sets flag, pin low.
// R2 - Period select 00=1/64 s, 01=1 s, 10=1 min, 11=1 hour.
// R3 - Mask bit 1 holds flag at 0 and pin open in any mode.
// R4 - Writing 0 to the flag clears it and releases the pin at once.
// R5 - Pulse mode clears flag and releases pin by itself after active time.
// R6 - Interrupt mode holds request until host writes 0; further events ignored.
// R7 - Busy is high during each counter increment cycle, low otherwise; with freeze set it is high only for the last 8 cycles before each seconds carry.
// R8 - Busy reads 1 while freeze bit is 0; host accesses when busy 0.
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "rpi_defs.vh"

module rpi_top #(
  parameter [21:0] TICK_CYCLES = `RPI_TICK_CYCLES,
  parameter [21:0] PULSE_CYCLES = `RPI_PULSE_CYCLES
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // AXI4-Lite write address and data.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response.
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read.
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Periodic open-drain pin and interrupt.
  output wire periodic_output_pin_o,
  output wire periodic_output_pin_oe,
  output wire irq
);

reg awready_q;
reg wready_q;
reg bvalid_q;
reg [1:0] bresp_q;
reg arready_q;
reg rvalid_q;
reg [31:0] rdata_q;
reg [1:0] rresp_q;
reg [7:0] waddr_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg [4:0] ctrl_q;
reg flag_q;
reg flag_d;
reg pin_oe_q;
reg pin_o_q;
reg [21:0] pulse_q;
reg istat_q;
reg ien_q;
reg irq_q;
reg ev;
reg [31:0] rd_mux;
reg rd_ok;
wire tick_64;
wire tick_sec;
wire tick_min;
wire tick_hour;
wire busy_win;
wire [5:0] sec_cnt;
wire [5:0] min_cnt;
wire wr_go;
wire wr_map;
wire flag_clr;
wire flag_set;
wire [1:0] period_select;
wire irq_or_pulse_select;
wire out_mask;
wire hold;
wire busy;

assign s_axi_awready = awready_q;
assign s_axi_wready = wready_q;
assign s_axi_bvalid = bvalid_q;
assign s_axi_bresp = bresp_q;
assign s_axi_arready = arready_q;
assign s_axi_rvalid = rvalid_q;
assign s_axi_rdata = rdata_q;
assign s_axi_rresp = rresp_q;
assign periodic_output_pin_o = pin_o_q;
assign periodic_output_pin_oe = pin_oe_q;
assign irq = irq_q;

assign hold = ctrl_q[`RPI_CTRL_HOLD];
assign period_select = ctrl_q[`RPI_CTRL_SEL_HI:`RPI_CTRL_SEL_LO];
assign irq_or_pulse_select = ctrl_q[`RPI_CTRL_MODE];
assign out_mask = ctrl_q[`RPI_CTRL_MASK];
// Without the freeze bit the busy state cannot be observed, so it reads as set.
assign busy = !hold || busy_win; // R8

////////////////////////////////////////////////////////////////////////////////
// Timebase.
rpi_period_gen #(
  .TICK_CYCLES(TICK_CYCLES)
) u_gen (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .tick_64(tick_64),
  .tick_sec(tick_sec),
  .tick_min(tick_min),
  .tick_hour(tick_hour),
  .busy_win(busy_win),
  .sec_cnt(sec_cnt),
  .min_cnt(min_cnt)
);

// Pick the event that drives the periodic output.
always @*
begin
  case (period_select)
    `RPI_SEL_64HZ: ev = tick_64; // R2
    `RPI_SEL_SEC: ev = tick_sec; // R2
    `RPI_SEL_MIN: ev = tick_min; // R2
    `RPI_SEL_HOUR: ev = tick_hour; // R2
    default: ev = 1'b0;
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Write path: address and data are captured independently, then committed together.
assign wr_go = !awready_q && !wready_q && !bvalid_q;
assign wr_map = (waddr_q == `RPI_OFS_CTRL) || (waddr_q == `RPI_OFS_FLAG) ||
                (waddr_q == `RPI_OFS_TIME) || (waddr_q == `RPI_OFS_ISTAT) ||
                (waddr_q == `RPI_OFS_IEN) || (waddr_q == `RPI_OFS_ICLR);
assign flag_clr = wr_go && (waddr_q == `RPI_OFS_FLAG) && wstrb_q[0] && !wdata_q[`RPI_FLAG_EVT]; // R4
assign flag_set = ev && (!flag_q || flag_clr); // R6

always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    awready_q <= 1'b1;
    wready_q <= 1'b1;
    bvalid_q <= 1'b0;
    bresp_q <= `RPI_RESP_OKAY;
    waddr_q <= 8'h00;
    wdata_q <= 32'h00000000;
    wstrb_q <= 4'h0;
    ctrl_q <= `RPI_CTRL_RESET;
    ien_q <= 1'b0;
  end
  else
  begin
    if (s_axi_awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      waddr_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_map ? `RPI_RESP_OKAY : `RPI_RESP_SLVERR;
      if ((waddr_q == `RPI_OFS_CTRL) && wstrb_q[0])
        ctrl_q <= wdata_q[4:0];
      if ((waddr_q == `RPI_OFS_IEN) && wstrb_q[0])
        ien_q <= wdata_q[0];
    end
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read path: one cycle from the address handshake to valid data.
always @*
begin
  rd_mux = 32'h00000000;
  rd_ok = 1'b1;
  case (s_axi_araddr)
    `RPI_OFS_CTRL: rd_mux = {27'h0000000, ctrl_q};
    `RPI_OFS_FLAG: rd_mux = {30'h00000000, busy, flag_q};
    `RPI_OFS_TIME: rd_mux = {18'h00000, min_cnt, 2'h0, sec_cnt};
    `RPI_OFS_ISTAT: rd_mux = {31'h00000000, istat_q};
    `RPI_OFS_IEN: rd_mux = {31'h00000000, ien_q};
    `RPI_OFS_ICLR: rd_mux = 32'h00000000;
    default: rd_ok = 1'b0;
  endcase
end

always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    arready_q <= 1'b1;
    rvalid_q <= 1'b0;
    rdata_q <= 32'h00000000;
    rresp_q <= `RPI_RESP_OKAY;
  end
  else
  begin
    if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_ok ? `RPI_RESP_OKAY : `RPI_RESP_SLVERR;
    end
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Event flag. A new event in the same cycle as a clear wins, so no period is lost.
always @*
begin
  flag_d = flag_q;
  if (out_mask)
    flag_d = 1'b0; // R3
  else if (flag_set)
    flag_d = 1'b1; // R1
  else if (flag_clr)
    flag_d = 1'b0; // R4
  else if (!irq_or_pulse_select && flag_q && (pulse_q == 22'h000000))
    flag_d = 1'b0; // R5
end

// The pin only ever pulls low; the pull-up supplies the high level when released.
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    flag_q <= 1'b0;
    pin_oe_q <= 1'b0;
    pin_o_q <= 1'b0;
    pulse_q <= 22'h000000;
  end
  else
  begin
    flag_q <= flag_d;
    pin_oe_q <= flag_d; // R1
    pin_o_q <= 1'b0;
    if (flag_set && !out_mask)
      pulse_q <= PULSE_CYCLES - 22'h000001; // R5
    else if (pulse_q != 22'h000000)
      pulse_q <= pulse_q - 22'h000001;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sticky status and level interrupt; a set beats a clear landing in the same cycle.
always @(posedge sys_clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    istat_q <= 1'b0;
    irq_q <= 1'b0;
  end
  else
  begin
    istat_q <= (istat_q && !(wr_go && (waddr_q == `RPI_OFS_ICLR) && wstrb_q[0] && wdata_q[0])) ||
               (flag_set && !out_mask);
    irq_q <= istat_q && ien_q;
  end
end

endmodule // rpi_top

// >>> tb/rpi_host.sv
// Host-side model: pull-up on the open-drain periodic pin.
// Assumes the block drives the pin only through its output enable.
`timescale 1ns/1ns
module rpi_host (
  // Pin drive from the block.
  input wire logic pin_o,
  input wire logic pin_oe,
  // Level the host sees.
  output wire logic pin_lvl
);
  // The pull-up wins whenever the block lets go, so a released pin never keeps a stale low.
  assign pin_lvl = pin_oe ? pin_o : 1'b1;
endmodule // rpi_host

// >>> tb/rpi_top_monitor.sv
// Checker for the periodic output block; it sees only the top-level ports.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module rpi_top_checker #(
  parameter [21:0] TICK_CYCLES = 22'h000040,
  parameter [21:0] PULSE_CYCLES = 22'h000010
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst_n,
  // Register bus.
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Periodic pin.
  input wire periodic_output_pin_o,
  input wire periodic_output_pin_oe
);
  int run_q;
  int gap_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Length of the current low drive, and cycles since the last one began.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= 0;
      gap_q <= 0;
    end
    else
    begin
      run_q <= periodic_output_pin_oe ? run_q + 1 : 0;
      gap_q <= $rose(periodic_output_pin_oe) ? 0 : gap_q + 1;
    end
  end
  AST_PIN_ZERO:
    assert property (periodic_output_pin_o == 1'b0) else $error("pin data not low");
  AST_PULSE_LEN:
    assert property ($fell(periodic_output_pin_oe) |-> $rose(s_axi_bvalid) || run_q == PULSE_CYCLES)
    else $error("pin released at wrong time");
  AST_RISE_GAP:
    assert property ($rose(periodic_output_pin_oe) |-> gap_q >= TICK_CYCLES - 4) else $error("events too close");
  AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_B_AFTER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("no write response");
  AST_W_BLOCK:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  AST_R_SLVERR:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h40 |=> s_axi_rvalid && s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  AST_RD_UPPER:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h00000) else $error("upper read bits set");
endmodule // rpi_top_checker

bind rpi_top rpi_top_checker #(.TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .periodic_output_pin_o(periodic_output_pin_o),
  .periodic_output_pin_oe(periodic_output_pin_oe));

// >>> tb/rpi_top_bench.sv
// Self-checking bench for the periodic output block with a short tick.
// Assumes the host model supplies the pull-up on the periodic pin.
`timescale 1ns/1ns
module rpi_top_bench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rd_data;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] rd_resp;
  wire awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, irq, pin_lvl;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int failures = 0, num_checks = 0, n, m;

  // A 64-cycle tick and a 16-cycle pulse keep the run short; every expected time follows from them.
  rpi_top #(.TICK_CYCLES(22'h000040), .PULSE_CYCLES(22'h000010)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periodic_output_pin_o(pin_o), .periodic_output_pin_oe(pin_oe), .irq(irq));
  rpi_host u_host (.pin_o(pin_o), .pin_oe(pin_oe), .pin_lvl(pin_lvl));

  // 250 MHz clock.
  always #2 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and bus tasks; each holds its request until the ready edge.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (awvalid || wvalid);
    while (!bvalid) @(posedge sys_clk);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
    rd_data = rdata;
    rd_resp = rresp;
  endtask
  task wait_oe(input logic v);
    while (pin_oe !== v) @(posedge sys_clk);
  endtask
  task period(input int exp);
    wait_oe(1'b1);
    n = 0;
    while (pin_oe) begin @(posedge sys_clk); n++; end
    while (!pin_oe) begin @(posedge sys_clk); n++; end
    chk(n, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task t_regs;
    rd(8'h00);
    chk(rd_data, 32'h00000000);
    rd(8'h04);
    chk(rd_data, 32'h00000002);
    rd(8'h40);
    chk(rd_resp, 2'h2);
    // A read whose ready comes late, so the read data must stand while the host stalls.
    @(posedge sys_clk);
    araddr <= 8'h08;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rready <= 1'b1;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
    chk(rdata, 32'h00000000);
    for (int s = 3; s >= 0; s--)
    begin
      wr(8'h00, s << 1);
      rd(8'h00);
      chk(rd_data, s << 1);
    end
  endtask
  task t_pulse;
    wait_oe(1'b1);
    chk(pin_lvl, 1'b0);
    repeat (12) @(posedge sys_clk);
    chk(pin_oe, 1'b1);
    repeat (8) @(posedge sys_clk);
    chk(pin_lvl, 1'b1);
    period(64);
    wait_oe(1'b1);
    wr(8'h04, 32'h0);
    chk(pin_oe, 1'b0);
  endtask
  task t_irq;
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h8);
    wait_oe(1'b1);
    repeat (200) @(posedge sys_clk);
    chk({pin_lvl, irq}, 2'b01);
    wr(8'h04, 32'h0);
    chk(pin_oe, 1'b0);
    wr(8'h00, 32'h10);
    wr(8'h14, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(irq, 1'b0);
  endtask
  task t_mask;
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, 32'h10 | (k << 3));
      m = 0;
      repeat (200) begin @(posedge sys_clk); m += pin_oe; end
      chk(m, 0);
      rd(8'h04);
      chk(rd_data, 32'h00000002);
    end
  endtask
  task t_busy;
    wr(8'h00, 32'h1);
    n = 0;
    m = 0;
    repeat (1500) begin rd(8'h04); if (rd_data[1]) n++; else m++; end
    chk(n > 0 && m > 0, 1'b1);
  endtask
  task print_verdict;
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence after five reset cycles.
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs;
    wr(8'h00, 32'h0);
    t_pulse;
    wr(8'h00, 32'h2);
    period(4096);
    t_irq;
    t_mask;
    t_busy;
    print_verdict;
  end
  // Watchdog sized well above the roughly 13k cycles the tests need.
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    print_verdict;
  end
endmodule // rpi_top_bench
